// ### rtl/setws_pkg.sv
// constants, types and helpers shared by the two-wire eeprom slave
package setws_pkg;

  // array geometry
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned MEM_DEPTH  = 128;
  localparam int unsigned PAGE_BYTES = 8;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned SEL_W      = 3;
  localparam int unsigned TYPE_W     = 4;

  // bit positions inside the address byte
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned SEL_LSB  = 1;
  localparam int unsigned DIR_BIT  = 0;

  // bit counter values within one byte
  localparam logic [3:0] BIT_LAST_IN = 4'h7;
  localparam logic [3:0] BIT_FULL    = 4'h8;

  // reset values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [5:0] SYNC_RST    = 6'h03;

  // internal programming time and its cycle count at the core clock
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned PROG_TIME_NS    = 5000000;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W      = 18;

  // bus sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEVACK,
    ST_WADDR,
    ST_WADDRACK,
    ST_WDATA,
    ST_WDATAACK,
    ST_RDATA,
    ST_RACK,
    ST_WAITSTOP,
    ST_PROG
  } setws_state_t;

  // next address inside the same page: low bits wrap, upper bits hold
  function automatic logic [ADDR_W-1:0] setws_page_next(input logic [ADDR_W-1:0] a);
    logic [PAGE_W-1:0] low;
    low = a[PAGE_W-1:0] + 3'h1;
    return {a[ADDR_W-1:PAGE_W], low};
  endfunction : setws_page_next

endpackage : setws_pkg

// ### rtl/setws_sync.sv
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module setws_sync #(
  parameter int unsigned W       = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import setws_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } setws_sync_t;

  setws_sync_t r_r;
  setws_sync_t r_nxt;

  // first stage feeds only the second stage
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.s2;

endmodule : setws_sync

// ### rtl/setws_mem.sv
// 128 x 8 storage array with an eight byte page commit port
`timescale 1ns/1ps
module setws_mem #(
  parameter int unsigned DEPTH = setws_pkg::MEM_DEPTH
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic [setws_pkg::ADDR_W-1:0]           rd_addr,
  output logic      [7:0]                             rd_data,
  input  wire logic                                   commit,
  input  wire logic [setws_pkg::ADDR_W-setws_pkg::PAGE_W-1:0] page,
  input  wire logic [setws_pkg::PAGE_BYTES-1:0][7:0]  pbuf,
  input  wire logic [setws_pkg::PAGE_BYTES-1:0]       pmask
);
  import setws_pkg::*;

  logic [7:0] mem_r [DEPTH];

  // array starts erased; a commit writes every marked byte of one page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else if (commit) begin
      for (int j = 0; j < PAGE_BYTES; j++) begin
        if (pmask[j]) begin
          mem_r[{page, PAGE_W'(j)}] <= pbuf[j];
        end
      end
    end
  end

  // read port follows the address counter
  assign rd_data = mem_r[rd_addr];

endmodule : setws_mem

// ### rtl/setws_top.sv
// two-wire serial eeprom slave: bus sequencer, page buffer and program timer
//
// Operation
// (R1) sample sda on each scl rising edge
// (R2) change driven sda only after scl falls
// (R3) start is sda falling with scl high
// (R4) stop is sda rising with scl high
// (R5) write without stop is discarded
// (R6) upper four address bits must match type
// (R7) next three bits must match select pins
// (R8) last address bit: one read, zero write
// (R9) write protect high refuses all writes
// (R10) ninth clock carries the acknowledge, low
// (R11) acknowledge address, word address and data
// (R12) read: low ack continues, high waits stop
// (R13) byte write programs only after stop
// (R14) page write increments only low bits
// (R15) more than eight bytes wrap in page
// (R16) reads leave counter one past last
// (R17) writes leave counter at last address
// (R18) reads continue sequentially over whole array
// (R19) random read via word address, restart
// (R20) master ends reads with high ack
// (R21) write protect counts from first byte low bit
// (R22) write protect aborts programming at once
// (R23) no acknowledge while programming
// (R24) start then stop cancels the command
// (R25) word address uses low seven bits
`timescale 1ns/1ps
module setws_top #(
  parameter logic [3:0]  TYPE_CODE   = 4'h5,  // arbitrary value
  parameter int unsigned PROG_CYCLES = setws_pkg::PROG_CYCLES_DEF
) (
  input  wire logic                        MCLK,
  input  wire logic                        RST_N,
  input  wire logic                        SCL,
  input  wire logic                        SDA_I,
  output logic                             SDA_O,
  output logic                             SDA_OE,
  input  wire logic                        WP,
  input  wire logic [setws_pkg::SEL_W-1:0] ADDR_SEL,
  output logic                             PROG_BUSY
);
  import setws_pkg::*;

  typedef struct packed {
    setws_state_t                  state;
    logic [3:0]                    cnt;
    logic [7:0]                    shreg;
    logic [7:0]                    txsh;
    logic [ADDR_W-1:0]             addr;
    logic                          got_data;
    logic                          wp_arm;
    logic                          wr_cancel;
    logic [PAGE_BYTES-1:0][7:0]    pbuf;
    logic [PAGE_BYTES-1:0]         pmask;
    logic [PROG_CNT_W-1:0]         tmr;
    logic                          scl_d;
    logic                          sda_d;
    logic                          oe;
    logic                          commit;
  } setws_core_t;

  setws_core_t r_r;
  setws_core_t r_nxt;

  logic [5:0]        pins_s;
  logic              scl_s;
  logic              sda_s;
  logic              wp_s;
  logic [SEL_W-1:0]  sel_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              dev_match;
  logic [7:0]        rd_data;
  logic [ADDR_W-1:0] wr_pos;

  // all bus pins cross into the core clock through two flops
  setws_sync #(
    .W       (6),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({ADDR_SEL, WP, SDA_I, SCL}),
    .q     (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign wp_s  = pins_s[2];
  assign sel_s = pins_s[5:3];

  // edge and bus condition detection on the synchronised lines
  assign scl_rise = scl_s & ~r_r.scl_d;
  assign scl_fall = ~scl_s & r_r.scl_d;
  assign start_c  = r_r.sda_d & ~sda_s & scl_s & r_r.scl_d;  // R3
  assign stop_c   = ~r_r.sda_d & sda_s & scl_s & r_r.scl_d;  // R4

  // address byte decode: type code, select pins
  assign dev_match = (r_r.shreg[7:TYPE_LSB] == TYPE_CODE)    // R6
                   && (r_r.shreg[TYPE_LSB-1:SEL_LSB] == sel_s);  // R7

  // first data byte lands at the word address, later ones wrap in page
  assign wr_pos = r_r.got_data ? setws_page_next(r_r.addr) : r_r.addr;  // R14 R15

  // storage array
  setws_mem u_mem (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .rd_addr (r_r.addr),
    .rd_data (rd_data),
    .commit  (r_r.commit),
    .page    (r_r.addr[ADDR_W-1:PAGE_W]),
    .pbuf    (r_r.pbuf),
    .pmask   (r_r.pmask)
  );

  // bus sequencer
  always_comb begin
    r_nxt        = r_r;
    r_nxt.scl_d  = scl_s;
    r_nxt.sda_d  = sda_s;
    r_nxt.commit = 1'b0;
    if (r_r.state == ST_PROG) begin
      // programming ignores the bus entirely, so polls get no acknowledge
      r_nxt.oe = 1'b0;  // R23
      if (wp_s) begin
        r_nxt.state = ST_IDLE;  // R22
      end else if (r_r.tmr == PROG_CNT_W'(PROG_CYCLES - 1)) begin
        r_nxt.commit = 1'b1;
        r_nxt.state  = ST_IDLE;
      end else begin
        r_nxt.tmr = r_r.tmr + 18'h00001;
      end
    end else if (start_c) begin
      // a new or repeated start drops any unfinished write
      r_nxt.state     = ST_DEVADDR;  // R3
      r_nxt.cnt       = 4'h0;
      r_nxt.oe        = 1'b0;
      r_nxt.got_data  = 1'b0;  // R5
      r_nxt.pmask     = '0;
      r_nxt.wp_arm    = 1'b0;
      r_nxt.wr_cancel = 1'b0;
    end else if (stop_c) begin
      // stop ends the transaction; only a clean data phase programs
      r_nxt.oe    = 1'b0;
      r_nxt.state = ST_IDLE;  // R24
      if ((r_r.state == ST_WDATA || r_r.state == ST_WDATAACK) && r_r.got_data
          && !r_r.wr_cancel && !wp_s) begin
        r_nxt.state = ST_PROG;  // R13
        r_nxt.tmr   = '0;
      end
    end else begin
      unique case (r_r.state)
        ST_IDLE, ST_WAITSTOP: begin
          r_nxt.oe = 1'b0;  // R12
        end
        ST_DEVADDR, ST_WADDR, ST_WDATA: begin
          if (scl_rise) begin
            r_nxt.shreg = {r_r.shreg[6:0], sda_s};  // R1
            r_nxt.cnt   = r_r.cnt + 4'h1;
            if (r_r.state == ST_WDATA && r_r.cnt == BIT_LAST_IN) begin
              r_nxt.wp_arm = 1'b1;  // R21
            end
          end else if (scl_fall && r_r.cnt == BIT_FULL) begin
            r_nxt.cnt = 4'h0;
            if (r_r.state == ST_DEVADDR) begin
              if (dev_match) begin
                r_nxt.oe    = 1'b1;  // R11
                r_nxt.state = ST_DEVACK;
              end else begin
                r_nxt.state = ST_IDLE;  // R6
              end
            end else if (r_r.state == ST_WADDR) begin
              r_nxt.addr     = r_r.shreg[ADDR_W-1:0];  // R25
              r_nxt.got_data = 1'b0;
              r_nxt.oe       = 1'b1;  // R11
              r_nxt.state    = ST_WADDRACK;
            end else if (r_r.wr_cancel) begin
              r_nxt.state = ST_IDLE;  // R9
            end else begin
              // store the byte and keep the counter on it
              r_nxt.pbuf[wr_pos[PAGE_W-1:0]]  = r_r.shreg;  // R15
              r_nxt.pmask[wr_pos[PAGE_W-1:0]] = 1'b1;
              r_nxt.addr     = wr_pos;  // R17
              r_nxt.got_data = 1'b1;
              r_nxt.oe       = 1'b1;  // R11
              r_nxt.state    = ST_WDATAACK;
            end
          end
        end
        ST_DEVACK: begin
          if (scl_fall) begin
            if (r_r.shreg[DIR_BIT]) begin
              // read: first data bit goes out on the same falling edge
              r_nxt.txsh  = rd_data;  // R8 R19
              r_nxt.oe    = ~rd_data[7];
              r_nxt.state = ST_RDATA;
            end else begin
              r_nxt.oe    = 1'b0;
              r_nxt.state = ST_WADDR;  // R8
            end
          end
        end
        ST_WADDRACK, ST_WDATAACK: begin
          if (scl_fall) begin
            r_nxt.oe    = 1'b0;  // R10
            r_nxt.state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_r.cnt == BIT_FULL) begin
              r_nxt.oe    = 1'b0;  // R10
              r_nxt.cnt   = 4'h0;
              r_nxt.state = ST_RACK;
            end else begin
              r_nxt.txsh = {r_r.txsh[6:0], 1'b0};
              r_nxt.oe   = ~r_r.txsh[6];  // R2
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            r_nxt.addr = r_r.addr + 7'h01;  // R16 R18
            if (sda_s) begin
              r_nxt.state = ST_WAITSTOP;  // R12 R20
            end
          end else if (scl_fall) begin
            r_nxt.txsh  = rd_data;  // R18
            r_nxt.oe    = ~rd_data[7];  // R2
            r_nxt.state = ST_RDATA;
          end
        end
        default: begin
          r_nxt.state = ST_IDLE;
          r_nxt.oe    = 1'b0;
        end
      endcase
    end
    // once armed, a high protect level cancels the pending write
    if (r_nxt.wp_arm && wp_s) begin
      r_nxt.wr_cancel = 1'b1;  // R21 R9
    end
  end

  // state register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r_r <= '{state: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // open drain: the pad only ever pulls low
  assign SDA_O     = 1'b0;
  assign SDA_OE    = r_r.oe;
  assign PROG_BUSY = (r_r.state == ST_PROG);

  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  start_enters_addr_a: assert property ( // R3
    (start_c && r_r.state != ST_PROG) |=> (r_r.state == ST_DEVADDR && r_r.cnt == 4'h0))
    else $error("start did not open address phase");

  sda_after_fall_a: assert property ( // R2
    ($rose(r_r.oe) || $fell(r_r.oe)) |-> ($past(scl_fall) || $past(r_r.state == ST_PROG)))
    else $error("sda drive changed without scl falling edge");

  prog_no_ack_a: assert property ( // R23
    (r_r.state == ST_PROG) |-> !r_r.oe)
    else $error("acknowledge driven while programming");

  wp_abort_prog_a: assert property ( // R22
    (r_r.state == ST_PROG && wp_s) |=> (r_r.state == ST_IDLE && !r_r.commit))
    else $error("protect did not abort programming");

  nack_waits_stop_a: assert property ( // R12
    (r_r.state == ST_RACK && scl_rise && sda_s && !start_c && !stop_c)
    |=> (r_r.state == ST_WAITSTOP) ##1 (!r_r.oe))
    else $error("high acknowledge did not end the read");

  type_mismatch_a: assert property ( // R6
    (r_r.state == ST_DEVADDR && scl_fall && r_r.cnt == BIT_FULL && !start_c && !stop_c
     && r_r.shreg[7:TYPE_LSB] != TYPE_CODE) |=> (r_r.state == ST_IDLE && !r_r.oe))
    else $error("foreign type code acknowledged");

  page_upper_hold_a: assert property ( // R14
    (r_r.state == ST_WDATAACK && $past(r_r.state) == ST_WDATA && $past(r_r.got_data))
    |-> (r_r.addr[ADDR_W-1:PAGE_W] == $past(r_r.addr[ADDR_W-1:PAGE_W])))
    else $error("page write changed upper address bits");

  read_advance_a: assert property ( // R16
    (r_r.state == ST_RACK && scl_rise && !start_c && !stop_c)
    |=> (r_r.addr == $past(r_r.addr) + 7'h01))
    else $error("read did not advance the address counter");

  prog_after_stop_a: assert property ( // R13
    $rose(r_r.state == ST_PROG) |-> $past(stop_c))
    else $error("programming began without stop");

  prog_len_a: assert property ( // R13
    (r_r.commit) |-> ($past(r_r.state) == ST_PROG && $past(r_r.tmr) == PROG_CNT_W'(PROG_CYCLES - 1)))
    else $error("commit outside programming end");

  cover_seq_read_c: cover property (
    (r_r.state == ST_RACK && scl_rise && !sda_s) ##[1:400] (r_r.state == ST_RDATA));
  cover_commit_c: cover property (r_r.commit);
  cover_page_wrap_c: cover property (
    (r_r.state == ST_WDATAACK && r_r.pmask == 8'hFF && r_r.addr[PAGE_W-1:0] == 3'h7));
  cover_wp_cancel_c: cover property ($rose(r_r.wr_cancel));

endmodule : setws_top

// ### tb/setws_host.sv
// bus master model for the two-wire eeprom slave
`timescale 1ns/1ps
module setws_host #(
  parameter int unsigned Q = 6
) (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic drv_low = 1'b0;

  // open-drain data line with pull-up: low if either party pulls
  assign sda = ~(drv_low | sda_oe);

  initial begin
    scl = 1'b1;
  end

  // quarter-bit wait, aligned to the falling clock edge
  task automatic w();
    repeat (Q) @(negedge clk);
  endtask : w

  // start, also used as repeated start
  task automatic start();
    drv_low = 1'b0;
    w();
    scl = 1'b1;
    w();
    drv_low = 1'b1;
    w();
    scl = 1'b0;
    w();
  endtask : start

  // stop closes a transfer; rd and t_cancel end a write phase with a repeated start instead
  task automatic stop();
    drv_low = 1'b1;
    w();
    scl = 1'b1;
    w();
    drv_low = 1'b0;
    w();
  endtask : stop

  // one bit: data set while clock low, line sampled in high phase
  task automatic bitx(input logic b, output logic r);
    drv_low = ~b;
    w();
    scl = 1'b1;
    w();
    r = sda;
    w();
    scl = 1'b0;
    w();
  endtask : bitx

  // byte out, msb first; line released for the ninth clock
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte

  // byte in; a high acknowledge ends the read
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(last, r);
  endtask : rbyte
endmodule : setws_host

// ### tb/test_setws_top.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_setws_top;
  import setws_pkg::*;
  localparam logic [3:0] TC  = 4'h5; // arbitrary value
  localparam logic [2:0] SEL = 3'h6;
  localparam int         PC  = 400;
  logic       mclk;
  logic       rst_n;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       wp;
  logic       busy;
  logic       ack;
  logic       oe_q = 1'b0;
  logic       sda_o;
  logic [2:0] sel = SEL;
  logic [7:0] d;
  logic [7:0] mem [MEM_DEPTH];
  logic [6:0] ca;
  int         error_cnt;
  int         checks;

  setws_top #(.TYPE_CODE(TC), .PROG_CYCLES(PC)) u_setws_top (
    .MCLK(mclk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .WP(wp), .ADDR_SEL(sel), .PROG_BUSY(busy));

  setws_host u_setws_host (.clk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // core clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // device may move its data line only while the clock is low
  always @(negedge mclk) begin
    if (sda_oe !== oe_q) begin
      `CHK("oe at scl high", 1'b0, scl)
    end
    if (sda_oe === 1'b1) begin
      `CHK("sda pull level", 1'b0, sda_o)
    end
    oe_q <= sda_oe;
  end

  function automatic logic [7:0] dev(input logic rd);
    return {TC, SEL, rd};
  endfunction : dev

  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // bounded wait on the busy flag
  task automatic wait_busy(input logic v, input int n);
    int k;
    k = 0;
    while (busy !== v && k < n) begin
      @(negedge mclk);
      k++;
    end
    `CHK("busy", v, busy)
    if (busy !== v) finish_test();
  endtask : wait_busy

  // write n bytes; md 0 refused, 1 normal with polling, 2 aborted
  task automatic wr(input logic [7:0] wa, input int n, input logic [7:0] b, input int md);
    logic [6:0] a;
    a = wa[6:0];
    u_setws_host.start();
    u_setws_host.wbyte(dev(1'b0), ack);
    `CHK("dev ack", 1'b1, ack)
    u_setws_host.wbyte(wa, ack);
    `CHK("word ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      u_setws_host.wbyte(b + 8'(i), ack);
      `CHK("data ack", md != 0, ack)
      if (md == 1) begin
        mem[a] = b + 8'(i);
        ca = a;
      end
      a = {a[6:3], a[2:0] + 3'h1};
    end
    `CHK("busy early", 1'b0, busy)
    u_setws_host.stop();
    if (md == 0) begin
      `CHK("busy", 1'b0, busy)
    end else if (md == 1) begin
      wait_busy(1'b1, 8);
      u_setws_host.start();
      u_setws_host.wbyte(dev(1'b0), ack);
      `CHK("poll ack", 1'b0, ack)
      u_setws_host.stop();
      wait_busy(1'b0, PC);
    end else begin
      wait_busy(1'b1, 8);
      wp = 1'b1;
      wait_busy(1'b0, 6);
      wp = 1'b0;
    end
  endtask : wr

  // current read of n bytes from the model counter
  task automatic cur(input int n);
    u_setws_host.start();
    u_setws_host.wbyte(dev(1'b1), ack);
    `CHK("rd ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      u_setws_host.rbyte(i == n - 1, d);
      `CHK("rd data", mem[ca], d)
      ca = ca + 7'h1;
    end
    u_setws_host.stop();
  endtask : cur

  // random read: word address with top bit set, then restart
  task automatic rd(input logic [6:0] a, input int n);
    u_setws_host.start();
    u_setws_host.wbyte(dev(1'b0), ack);
    u_setws_host.wbyte({1'b1, a}, ack);
    `CHK("addr ack", 1'b1, ack)
    ca = a;
    cur(n);
  endtask : rd

  task automatic t_byte();
    wr(8'h92, 1, 8'hA5, 1);
    cur(1);
    rd(7'h12, 1);
    cur(1);
  endtask : t_byte

  task automatic t_page();
    wr(8'h25, 10, 8'h30, 1);
    cur(1);
    rd(7'h20, 9);
    rd(7'h7E, 4);
  endtask : t_page

  // foreign select or type code gets no acknowledge
  task automatic nak(input logic [7:0] b);
    u_setws_host.start();
    u_setws_host.wbyte(b, ack);
    `CHK("no ack", 1'b0, ack)
    u_setws_host.stop();
  endtask : nak

  task automatic t_mismatch();
    for (int i = 0; i < 3; i++) begin
      nak({TC, SEL ^ (3'h1 << i), 1'b0});
    end
    nak({~TC, SEL, 1'b1});
    sel = ~SEL;
    nak(dev(1'b0));
    sel = SEL;
    repeat (4) @(negedge mclk);
    rd(7'h00, 1);
  endtask : t_mismatch

  // restart discards a write, start then stop cancels
  task automatic t_cancel();
    u_setws_host.start();
    u_setws_host.wbyte(dev(1'b0), ack);
    u_setws_host.wbyte(8'h40, ack);
    u_setws_host.wbyte(8'h77, ack);
    u_setws_host.start();
    u_setws_host.stop();
    repeat (10) @(negedge mclk);
    `CHK("busy", 1'b0, busy)
    rd(7'h40, 1);
  endtask : t_cancel

  task automatic t_wp();
    wp = 1'b1;
    wr(8'h50, 1, 8'h11, 0);
    wp = 1'b0;
    wr(8'h51, 1, 8'h22, 2);
    rd(7'h50, 2);
  endtask : t_wp

  // hang guard
  initial begin
    repeat (100000) @(negedge mclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    error_cnt = 0;
    checks    = 0;
    rst_n     = 1'b0;
    wp        = 1'b0;
    ca        = 7'h00;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_byte();
    t_page();
    t_mismatch();
    t_cancel();
    t_wp();
    finish_test();
  end
endmodule : test_setws_top
